// ---- rtl/scp_map.svh ----
// offsets, field positions, reset values and counts of the protection block
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
`define SCP_CFG_OFS 8'h00
`define SCP_PROT_OFS 8'h04
`define SCP_SVC_OFS 8'h08
`define SCP_RSR_OFS 8'h0C
`define SCP_ARB_OFS 8'h10
`define SCP_CFG_SHOW 4
`define SCP_CFG_MM 6
`define SCP_CFG_SUPERVISOR_RESTRICT_BIT 7
`define SCP_CFG_SLV 8
`define SCP_CFG_FREEZE_BUS_MONITOR_BIT 9
`define SCP_CFG_FREEZE_WATCHDOG_BIT 10
`define SCP_PROT_SWT 0
`define SCP_PROT_SWP 2
`define SCP_PROT_BMT 3
`define SCP_PROT_BME 5
`define SCP_PROT_HME 6
`define SCP_PROT_SWE 7
`define SCP_CFG_RST 32'h0000_00CF
`define SCP_CFG_WMASK 32'h0000_06FF
`define SCP_PROT_RST 32'h0000_0000
`define SCP_PROT_WMASK 32'h0000_00FF
`define SCP_RSR_POR 4'h8
`define SCP_BASE_LO 24'h7FF000
`define SCP_BASE_HI 24'hFFF000
`define SCP_BLOCK_SIZE 24'h001000
`define SCP_SVC_ARM 8'h55
`define SCP_SVC_DONE 8'hAA
`define SCP_PRE_LAST 9'h1FF
`define SCP_WD_EXP0 5'h09
`define SCP_BM_MAX 7'h40
`define SCP_RESP_OK 2'h0
`define SCP_RESP_SLV 2'h2
`define SCP_RESP_DEC 2'h3
`endif

// ---- rtl/scp_pkg.sv ----
// shared types of the configuration and protection block
package scp_pkg;
  typedef enum logic [0:0] {ARB_IDLE, ARB_BIT} scp_arb_e;
  typedef logic [1:0] scp_resp_t;
endpackage

// ---- rtl/scp_bus_monitor.sv ----
// bus response monitor: counts clocks of a bus cycle until acknowledge
`timescale 1ns/100ps
`include "scp_map.svh"
module scp_bus_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cyc_start,
  input wire logic cyc_ext,
  input wire logic data_size_acknowledge,
  input wire logic autovector_request,
  input wire logic byte_pair_first,
  input wire logic bus_monitor_enable,
  input wire logic [1:0] bus_timeout_select,
  input wire logic freeze,
  input wire logic freeze_bus_monitor_bit,
  input wire logic low_power_stop,
  output logic bus_timeout
);
  import scp_pkg::*;
  logic active_r, active_nxt, to_r, to_nxt, ack, mon_ok;
  logic [6:0] cnt_r, cnt_nxt, lim;

  // limit halves for each step of the select code
  assign lim = `SCP_BM_MAX >> bus_timeout_select;
  assign ack = data_size_acknowledge | autovector_request;
  assign mon_ok = !(freeze && freeze_bus_monitor_bit) && !low_power_stop;
  assign bus_timeout = to_r;

  // start, count, acknowledge; an acknowledge on the first of a byte pair is ignored
  always_comb begin
    active_nxt = active_r;
    cnt_nxt = cnt_r;
    to_nxt = 1'b0;
    if (active_r) begin
      if (ack && !byte_pair_first) begin
        active_nxt = 1'b0;
      end else if (!mon_ok) begin
        active_nxt = 1'b0;
      end else if (cnt_r + 7'h01 == lim) begin
        to_nxt = 1'b1;
        active_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r + 7'h01;
      end
    end else if (cyc_start && (!cyc_ext || bus_monitor_enable) && mon_ok) begin
      active_nxt = 1'b1;
      cnt_nxt = 7'h00;
    end
    if (!aresetn) begin
      active_nxt = 1'b0;
      cnt_nxt = 7'h00;
      to_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    active_r <= active_nxt;
    cnt_r <= cnt_nxt;
    to_r <= to_nxt;
  end

  property p_bm_eight;
    @(posedge aclk) disable iff (!aresetn)
    (!active_r && cyc_start && !cyc_ext && mon_ok && bus_timeout_select == 2'b11)
      ##1 (!ack && mon_ok && bus_timeout_select == 2'b11)[*8] |=> bus_timeout;
  endproperty
  a_bm_eight: assert property (p_bm_eight) else $error("bus monitor missed 8 clock limit");
  property p_bm_ack;
    @(posedge aclk) disable iff (!aresetn)
    active_r && ack && !byte_pair_first |=> !bus_timeout && !active_r;
  endproperty
  a_bm_ack: assert property (p_bm_ack) else $error("acknowledge did not end monitoring");
  c_bm_to: cover property (@(posedge aclk) disable iff (!aresetn) bus_timeout);
endmodule

// ---- rtl/scp_watchdog.sv ----
// software watchdog clocked by sampled crystal edges
`timescale 1ns/100ps
`include "scp_map.svh"
module scp_watchdog (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic crystal_input,
  input wire logic enable,
  input wire logic prescale,
  input wire logic [1:0] timing,
  input wire logic svc_wr,
  input wire logic [7:0] svc_data,
  input wire logic low_power_stop,
  input wire logic freeze,
  input wire logic freeze_watchdog_bit,
  output logic wd_fire,
  output logic wd_armed
);
  import scp_pkg::*;
  logic x_s1, x_s2, x_s3, tick, ptick, run, svc_done;
  logic arm_r, arm_nxt, fire_r, fire_nxt;
  logic [8:0] pre_r, pre_nxt;
  logic [15:0] cnt_r, cnt_nxt, lim;
  logic [1:0] swt_r, swt_nxt;

  // crystal is asynchronous: two flops, then an edge detector on the second
  always_ff @(posedge aclk) begin
    x_s1 <= crystal_input;
    x_s2 <= x_s1;
    x_s3 <= x_s2;
  end

  assign run = enable && !low_power_stop && !(freeze && freeze_watchdog_bit);
  assign tick = x_s2 && !x_s3 && run;
  assign ptick = prescale ? (tick && pre_r == `SCP_PRE_LAST) : tick;
  // timing field in force is the one latched at the last service
  assign lim = (16'h0001 << (`SCP_WD_EXP0 + {2'b00, swt_r, 1'b0})) - 16'h0001;
  assign svc_done = svc_wr && svc_data == `SCP_SVC_DONE && arm_r;
  assign wd_fire = fire_r;
  assign wd_armed = arm_r;

  // other values leave the sequence where it stands
  always_comb begin
    arm_nxt = arm_r;
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    swt_nxt = swt_r;
    fire_nxt = 1'b0;
    if (svc_wr && svc_data == `SCP_SVC_ARM) begin
      arm_nxt = 1'b1;
    end
    if (svc_done) begin
      arm_nxt = 1'b0;
      pre_nxt = 9'h000;
      cnt_nxt = 16'h0000;
      swt_nxt = timing;
    end else if (!enable) begin
      pre_nxt = 9'h000;
      cnt_nxt = 16'h0000;
    end else if (tick) begin
      pre_nxt = prescale ? pre_r + 9'h001 : 9'h000;
      if (ptick) begin
        if (cnt_r == lim) begin
          fire_nxt = 1'b1;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
    end
    if (!aresetn) begin
      arm_nxt = 1'b0;
      pre_nxt = 9'h000;
      cnt_nxt = 16'h0000;
      swt_nxt = 2'b00;
      fire_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    arm_r <= arm_nxt;
    pre_r <= pre_nxt;
    cnt_r <= cnt_nxt;
    swt_r <= swt_nxt;
    fire_r <= fire_nxt;
  end

  property p_wd_stop;
    @(posedge aclk) disable iff (!aresetn)
    low_power_stop && enable && !svc_done |=> $stable(cnt_r) && $stable(pre_r);
  endproperty
  a_wd_stop: assert property (p_wd_stop) else $error("watchdog moved in stop");
  property p_wd_svc;
    @(posedge aclk) disable iff (!aresetn)
    svc_done |=> cnt_r == 16'h0000 && !arm_r && swt_r == $past(timing);
  endproperty
  a_wd_svc: assert property (p_wd_svc) else $error("service did not restart count");
  c_wd_fire: cover property (@(posedge aclk) disable iff (!aresetn) wd_fire);
endmodule

// ---- rtl/scp_top.sv ----
// system configuration and protection block with axi4-lite registers
`timescale 1ns/100ps
`include "scp_map.svh"
module scp_top #(
  parameter int NMOD = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output scp_pkg::scp_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output scp_pkg::scp_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic data_line_eleven,
  input wire logic clock_mode_pin,
  input wire logic crystal_input,
  input wire logic low_power_stop,
  input wire logic freeze,
  input wire logic cyc_start,
  input wire logic cyc_ext,
  input wire logic data_size_acknowledge,
  input wire logic autovector_request,
  input wire logic byte_pair_first,
  input wire logic halt_in,
  input wire logic [NMOD-1:0] irq_req,
  input wire logic iack,
  output logic iack_done,
  output logic [$clog2(NMOD)-1:0] iack_winner,
  output logic iack_spurious,
  output logic internal_bus_error,
  output logic sys_reset_req,
  output logic [23:0] ctrl_block_base,
  output logic show_cycles_en,
  output logic ext_arb_en,
  output logic grant_halts,
  output logic slave_test_flag
);
  import scp_pkg::*;
  localparam int MW = $clog2(NMOD);
  localparam int FW = 4 * (NMOD - 1);
  logic d11_s1, d11_s2, mck_s1, mck_s2;
  logic [31:0] cfg_r, cfg_nxt, prot_r, prot_nxt, rd_val, wd_word;
  logic [FW-1:0] arbf_r, arbf_nxt;
  logic slave_r, slave_nxt, rstd_r, rstd_nxt;
  logic [3:0] rsr_r, rsr_nxt, wstrb_r, wstrb_nxt;
  logic pend_wd_r, pend_wd_nxt, pend_halt_r, pend_halt_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, awpriv_r, awpriv_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  scp_resp_t bresp_r, bresp_nxt, rresp_r, rresp_nxt, wr_resp;
  logic do_wr, svc_wr, wd_fire, bm_internal_bus_error, halt_hit;
  scp_arb_e st_r, st_nxt;
  logic [1:0] bit_r, bit_nxt;
  logic [NMOD-1:0] cand_r, cand_nxt, col, cand_m;
  logic [MW-1:0] win_r, win_nxt;
  logic done_r, done_nxt, spur_r, spur_nxt, sberr_r, sberr_nxt;
  logic [3:0] fld [NMOD];

  // unmapped gets decode error; user access blocked when restricted, except to the reset status register
  function automatic scp_resp_t acc_resp(input logic [7:0] a, input logic priv,
      input logic supervisor_restrict_bit);
    if (a != `SCP_CFG_OFS && a != `SCP_PROT_OFS && a != `SCP_SVC_OFS &&
        a != `SCP_RSR_OFS && a != `SCP_ARB_OFS) begin
      return `SCP_RESP_DEC;
    end
    if (supervisor_restrict_bit && !priv && a != `SCP_RSR_OFS) begin
      return `SCP_RESP_SLV;
    end
    return `SCP_RESP_OK;
  endfunction

  // byte-lane merge limited to writable bits
  function automatic logic [31:0] wr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{strb[b]}};
    end
    m = m & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // lowest index wins when fields tie, so the block's own request goes first
  function automatic logic [MW-1:0] first_set(input logic [NMOD-1:0] m);
    logic [MW-1:0] r;
    r = '0;
    for (int i = NMOD - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = MW'(i);
      end
    end
    return r;
  endfunction

  // strap pins are asynchronous to the bus clock
  always_ff @(posedge aclk) begin
    d11_s1 <= data_line_eleven;
    d11_s2 <= d11_s1;
    mck_s1 <= clock_mode_pin;
    mck_s2 <= mck_s1;
  end

  // configuration outputs
  assign ctrl_block_base = cfg_r[`SCP_CFG_MM] ? `SCP_BASE_HI : `SCP_BASE_LO;
  assign show_cycles_en = cfg_r[`SCP_CFG_SHOW +: 2] != 2'b00;
  assign ext_arb_en = cfg_r[`SCP_CFG_SHOW +: 2] != 2'b01;
  assign grant_halts = cfg_r[`SCP_CFG_SHOW +: 2] == 2'b11;
  assign slave_test_flag = slave_r;
  assign awready = !aw_have_r && !bvalid_r;
  assign wready = !w_have_r && !bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign wr_resp = acc_resp(awaddr_r, awpriv_r, cfg_r[`SCP_CFG_SUPERVISOR_RESTRICT_BIT]);
  assign svc_wr = do_wr && wr_resp == `SCP_RESP_OK && awaddr_r == `SCP_SVC_OFS && wstrb_r[0];
  assign wd_word = wr_merge(32'(arbf_r), wdata_r, wstrb_r, 32'hFFFF_FFFF);

  // read data; slave flag merged in, service register reads zero
  always_comb begin
    case (araddr)
      `SCP_CFG_OFS: rd_val = cfg_r | (32'(slave_r) << `SCP_CFG_SLV);
      `SCP_PROT_OFS: rd_val = prot_r;
      `SCP_RSR_OFS: rd_val = {28'h0000000, rsr_r};
      `SCP_ARB_OFS: rd_val = 32'(arbf_r);
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // register bus: address and data taken in either order, one write at a time
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    awpriv_nxt = awpriv_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    cfg_nxt = cfg_r;
    prot_nxt = prot_r;
    arbf_nxt = arbf_r;
    if (awvalid && awready) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = awaddr;
      awpriv_nxt = awprot[0];
    end
    if (wvalid && wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_resp;
      if (wr_resp == `SCP_RESP_OK) begin
        case (awaddr_r)
          `SCP_CFG_OFS: cfg_nxt = wr_merge(cfg_r, wdata_r, wstrb_r, `SCP_CFG_WMASK);
          `SCP_PROT_OFS: prot_nxt = wr_merge(prot_r, wdata_r, wstrb_r, `SCP_PROT_WMASK);
          `SCP_ARB_OFS: arbf_nxt = wd_word[FW-1:0];
          default: ;
        endcase
      end
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = acc_resp(araddr, arprot[0], cfg_r[`SCP_CFG_SUPERVISOR_RESTRICT_BIT]);
      rdata_nxt = (rresp_nxt == `SCP_RESP_OK) ? rd_val : 32'h0000_0000;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (!aresetn) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b0;
      rvalid_nxt = 1'b0;
      bresp_nxt = `SCP_RESP_OK;
      rresp_nxt = `SCP_RESP_OK;
      rdata_nxt = 32'h0000_0000;
      cfg_nxt = `SCP_CFG_RST;
      arbf_nxt = '0;
      // prescale is the inverse of the clock mode pin, software may change it later
      prot_nxt = `SCP_PROT_RST | (32'(!mck_s2) << `SCP_PROT_SWP);
    end
  end

  always_ff @(posedge aclk) begin
    aw_have_r <= aw_have_nxt;
    w_have_r <= w_have_nxt;
    awaddr_r <= awaddr_nxt;
    awpriv_r <= awpriv_nxt;
    wdata_r <= wdata_nxt;
    wstrb_r <= wstrb_nxt;
    bvalid_r <= bvalid_nxt;
    bresp_r <= bresp_nxt;
    rvalid_r <= rvalid_nxt;
    rdata_r <= rdata_nxt;
    rresp_r <= rresp_nxt;
    cfg_r <= cfg_nxt;
    prot_r <= prot_nxt;
    arbf_r <= arbf_nxt;
  end

  // reset causes: pending flags are captured by the block reset and then cleared; power-on also clears them
  assign halt_hit = aresetn && halt_in && prot_r[`SCP_PROT_HME] && !low_power_stop;
  assign sys_reset_req = pend_wd_r || pend_halt_r;
  always_comb begin
    rstd_nxt = !aresetn;
    slave_nxt = !aresetn ? !d11_s2 : slave_r;
    // causes captured on the first reset cycle, then the pending flags drop
    pend_wd_nxt = (pend_wd_r && !(rstd_r && !aresetn)) || wd_fire;
    pend_halt_nxt = (pend_halt_r && !(rstd_r && !aresetn)) || halt_hit;
    rsr_nxt = rsr_r;
    if (!aresetn && !rstd_r) begin
      rsr_nxt = {1'b0, !(pend_wd_r || pend_halt_r), pend_halt_r, pend_wd_r};
    end
    if (!por_n) begin
      rsr_nxt = `SCP_RSR_POR;
      pend_wd_nxt = 1'b0;
      pend_halt_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    rstd_r <= rstd_nxt;
    slave_r <= slave_nxt;
    pend_wd_r <= pend_wd_nxt;
    pend_halt_r <= pend_halt_nxt;
    rsr_r <= rsr_nxt;
  end

  // priority fields: index 0 is this block, others from the field register
  always_comb begin
    fld[0] = cfg_r[3:0];
    for (int i = 1; i < NMOD; i++) begin
      fld[i] = arbf_r[4*(i-1) +: 4];
    end
    for (int i = 0; i < NMOD; i++) begin
      col[i] = fld[i][bit_r];
    end
  end

  // serial contention, most significant field bit first
  assign cand_m = (|(cand_r & col)) ? (cand_r & col) : cand_r;
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    cand_nxt = cand_r;
    win_nxt = win_r;
    done_nxt = 1'b0;
    spur_nxt = 1'b0;
    sberr_nxt = 1'b0;
    case (st_r)
      ARB_IDLE: begin
        if (iack) begin
          st_nxt = ARB_BIT;
          bit_nxt = 2'h3;
          cand_nxt = irq_req;
        end
      end
      ARB_BIT: begin
        cand_nxt = cand_m;
        bit_nxt = bit_r - 2'h1;
        if (bit_r == 2'h0) begin
          st_nxt = ARB_IDLE;
          done_nxt = 1'b1;
          if (cand_m == '0) begin
            // no winner: report index zero rather than a stale one
            win_nxt = '0;
            sberr_nxt = 1'b1;
          end else begin
            win_nxt = first_set(cand_m);
            spur_nxt = fld[first_set(cand_m)] == 4'h0;
          end
        end
      end
      default: st_nxt = ARB_IDLE;
    endcase
    if (!aresetn) begin
      st_nxt = ARB_IDLE;
      bit_nxt = 2'h3;
      cand_nxt = '0;
      win_nxt = '0;
      done_nxt = 1'b0;
      spur_nxt = 1'b0;
      sberr_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
    bit_r <= bit_nxt;
    cand_r <= cand_nxt;
    win_r <= win_nxt;
    done_r <= done_nxt;
    spur_r <= spur_nxt;
    sberr_r <= sberr_nxt;
  end

  assign iack_done = done_r;
  assign iack_winner = win_r;
  assign iack_spurious = spur_r;
  assign internal_bus_error = bm_internal_bus_error || sberr_r;

  scp_bus_monitor u_bm (
    .aclk(aclk),
    .aresetn(aresetn),
    .cyc_start(cyc_start),
    .cyc_ext(cyc_ext),
    .data_size_acknowledge(data_size_acknowledge),
    .autovector_request(autovector_request),
    .byte_pair_first(byte_pair_first),
    .bus_monitor_enable(prot_r[`SCP_PROT_BME]),
    .bus_timeout_select(prot_r[`SCP_PROT_BMT +: 2]),
    .freeze(freeze),
    .freeze_bus_monitor_bit(cfg_r[`SCP_CFG_FREEZE_BUS_MONITOR_BIT]),
    .low_power_stop(low_power_stop),
    .bus_timeout(bm_internal_bus_error)
  );

  scp_watchdog u_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .crystal_input(crystal_input),
    .enable(prot_r[`SCP_PROT_SWE]),
    .prescale(prot_r[`SCP_PROT_SWP]),
    .timing(prot_r[`SCP_PROT_SWT +: 2]),
    .svc_wr(svc_wr),
    .svc_data(wdata_r[7:0]),
    .low_power_stop(low_power_stop),
    .freeze(freeze),
    .freeze_watchdog_bit(cfg_r[`SCP_CFG_FREEZE_WATCHDOG_BIT]),
    .wd_fire(wd_fire),
    .wd_armed()
  );

  property p_arb_time;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ARB_IDLE && iack |-> ##5 iack_done;
  endproperty
  a_arb_time: assert property (p_arb_time) else $error("acknowledge not resolved in 5");
  property p_spur;
    @(posedge aclk) disable iff (!aresetn)
    iack_spurious |-> iack_done && fld[iack_winner] == 4'h0;
  endproperty
  a_spur: assert property (p_spur) else $error("spurious with nonzero field");
  property p_rst_fields;
    @(posedge aclk) $rose(aresetn) |-> cfg_r[3:0] == 4'hF && arbf_r == '0;
  endproperty
  a_rst_fields: assert property (p_rst_fields) else $error("bad reset priority");
  property p_nowin;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ARB_IDLE && iack && irq_req == '0 |-> ##5 internal_bus_error;
  endproperty
  a_nowin: assert property (p_nowin) else $error("no winner without bus error");
  property p_base;
    @(posedge aclk) disable iff (!aresetn)
    $rose(cfg_r[`SCP_CFG_MM]) |-> ctrl_block_base == `SCP_BASE_HI;
  endproperty
  a_base: assert property (p_base) else $error("block base not moved");
  property p_user;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && cfg_r[`SCP_CFG_SUPERVISOR_RESTRICT_BIT] && !arprot[0] && araddr == `SCP_CFG_OFS
      |=> rvalid && rresp == `SCP_RESP_SLV;
  endproperty
  a_user: assert property (p_user) else $error("user read not refused");
  property p_halt;
    @(posedge aclk) disable iff (!aresetn) halt_hit |=> sys_reset_req[*2];
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not request reset");
  property p_cause;
    @(posedge aclk) disable iff (!por_n)
    !aresetn && !rstd_r && pend_wd_r |=> rsr_r[0] && !rsr_r[2];
  endproperty
  a_cause: assert property (p_cause) else $error("watchdog cause not latched");
  property p_slave;
    @(posedge aclk) $rose(aresetn) |-> slave_test_flag == !$past(d11_s2);
  endproperty
  a_slave: assert property (p_slave) else $error("slave flag not sampled");
  c_win: cover property (@(posedge aclk) disable iff (!aresetn) iack_done && !iack_spurious);
  c_wr_ok: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bresp == 2'h0);
endmodule

// ---- verif/scp_core_model.sv ----
// core-side bus cycle source for the bus monitor
`timescale 1ns/100ps
module scp_core_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] dly,
  output logic cyc_start,
  output logic data_size_acknowledge
);
  logic [7:0] cnt_r = 8'h00;
  // ack after dly clocks; zero never answers, forcing a time-out
  always @(posedge aclk) begin
    cyc_start <= go;
    data_size_acknowledge <= (cnt_r == 8'h01);
    cnt_r <= go ? dly : cnt_r - {7'h00, cnt_r != 8'h00};
  end
endmodule

// ---- verif/system_config_protection_test.sv ----
// self-checking bench of the configuration and protection block
`timescale 1ns/100ps
module system_config_protection_test;
  import scp_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic go = 0, crystal_input = 0, iack = 0, freeze = 0, halt_in = 0, low_power_stop = 0;
  logic cyc_ext = 0, autovector_request = 0, byte_pair_first = 0;
  logic data_line_eleven = 1, clock_mode_pin = 1;
  logic [2:0] awprot = 3'h1, arprot = 3'h1;
  logic [3:0] wstrb = 4'hF, irq_req = 4'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dly = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  scp_resp_t bresp, rresp, b;
  logic awready, wready, bvalid, arready, rvalid, iack_done, iack_spurious, internal_bus_error;
  logic sys_reset_req, show_cycles_en, ext_arb_en, grant_halts, slave_test_flag;
  logic cyc_start, data_size_acknowledge, ta, tw, tb;
  logic [1:0] iack_winner;
  logic [23:0] ctrl_block_base;
  logic por_n = 0;
  int n_mismatch = 0, n_tests = 0, n;
  scp_top uut (.*);
  scp_core_model core (.*);
  // clock; crystal gives one watchdog tick every four clocks
  always #5 aclk = ~aclk;
  always begin
    repeat (2) @(posedge aclk);
    crystal_input <= ~crystal_input;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // flags sampled mid-cycle so the edge never races the design
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      b = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tb = rvalid;
      d = rdata;
      b = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end while (!tb);
    rready <= 0;
  endtask
  // one bus cycle; n counts clocks until a bus error
  task bm(input logic [7:0] k);
    @(posedge aclk);
    dly <= k;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    n = 0;
    repeat (80) begin
      @(negedge aclk);
      if (internal_bus_error) break;
      n++;
    end
  endtask
  task ia(input logic [3:0] q, input logic [4:0] e);
    @(posedge aclk);
    irq_req <= q;
    iack <= 1;
    @(posedge aclk);
    iack <= 0;
    repeat (5) @(negedge aclk);
    chk({iack_done, iack_winner, iack_spurious, internal_bus_error}, e);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    por_n <= 1;
    rd(8'h00);
    chk(d, 32'h0000_00CF);
    rd(8'h10);
    chk(d, 32'h0);
    rd(8'h0C);
    chk(d, 32'h8);
    rd(8'h04);
    chk(d, 32'h0);
    rd(8'h40);
    chk(b, 2'h3);
    chk({ctrl_block_base, slave_test_flag}, {24'hFFF000, 1'b0});
    // user-level read while restricted must be refused
    arprot <= 3'h0;
    rd(8'h00);
    chk(b, 2'h2);
    arprot <= 3'h1;
    awprot <= 3'h0;
    wr(8'h00, 32'h0);
    chk(b, 2'h2);
    awprot <= 3'h1;
    wr(8'h00, 32'h0000_000F);
    chk({ctrl_block_base, show_cycles_en, ext_arb_en, grant_halts}, {24'h7FF000, 3'h2});
    awprot <= 3'h0;
    wr(8'h00, 32'h0000_007F);
    chk({b, show_cycles_en, ext_arb_en, grant_halts}, 5'h07);
    ia(4'h1, 5'h10);
    ia(4'h3, 5'h10);
    ia(4'h2, 5'h16);
    ia(4'h0, 5'h11);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, 32'(i << 3));
      bm(8'h00);
      chk(n, (64 >> i) + 1);
    end
    bm(8'h03);
    chk(n, 80);
    wr(8'h04, 32'h0000_0080);
    repeat (1500) @(negedge aclk);
    wr(8'h08, 32'h55);
    wr(8'h08, 32'h33);
    wr(8'h08, 32'hAA);
    repeat (1800) @(negedge aclk);
    chk(sys_reset_req, 0);
    repeat (400) @(negedge aclk);
    chk(sys_reset_req, 1);
    // block reset only: the watchdog cause must survive into the status register
    @(posedge aclk);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h0C);
    chk(d, 32'h1);
    chk(sys_reset_req, 0);
    // halt with the monitor enabled requests a reset
    awprot <= 3'h1;
    wr(8'h04, 32'h0000_0040);
    @(posedge aclk);
    halt_in <= 1;
    @(posedge aclk);
    halt_in <= 0;
    @(negedge aclk);
    chk(sys_reset_req, 1);
    finish_test;
  end
  // hang guard, well past the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test;
  end
endmodule
